// *** verilog/pwr_defs.svh ***
`ifndef PWR_DEFS_SVH
`define PWR_DEFS_SVH
`define CLK_HZ 25000000
`define HOLD_ON_MS 1000
`define POR_MS 240
`define HOLD_ON_CYC ((`CLK_HZ / 1000) * `HOLD_ON_MS)
`define POR_CYC ((`CLK_HZ / 1000) * `POR_MS)
`define CNT_W 25
`define SYNC_LAT 3
`define FEAT_INT_OFF_EN 8'h53
`define FEAT_INT_OFF_DIS 8'h54
`define BOOT_DOWNLOAD 1'h0
`endif

// *** verilog/pwr_pkg.sv ***
package pwr_pkg;
  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_HOLD = 3'b001,
    ST_POR = 3'b010,
    ST_INIT = 3'b011,
    ST_ON = 3'b100,
    ST_EXT_RST = 3'b101
  } pwr_state_type;
endpackage

// *** verilog/pin_sync_if.sv ***
`timescale 1ns/1ps
interface pin_sync_if;
  logic on_lvl;
  logic rst_lvl_n;
  logic active_low_interrupt_pin_fall;
  modport src (output on_lvl, output rst_lvl_n, output active_low_interrupt_pin_fall);
  modport dst (input on_lvl, input rst_lvl_n, input active_low_interrupt_pin_fall);
endinterface

// *** verilog/pin_sync.sv ***
`timescale 1ns/1ps
module pin_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic on_pin,
  input wire logic rst_pin_n,
  input wire logic active_low_interrupt_pin,
  pin_sync_if.src sy
);
  logic [2:0] s1_ff;
  logic [2:0] s2_ff;
  logic active_low_interrupt_pin_d_ff;
  logic [2:0] nxt_s1;
  logic [2:0] nxt_s2;
  logic nxt_active_low_interrupt_pin_d;

  // The reset and interrupt pins idle high and the on pin low, so power-up does not read a phantom falling edge.
  always_comb
  begin
    nxt_s1 = ce ? {active_low_interrupt_pin, rst_pin_n, on_pin} : s1_ff;
    nxt_s2 = ce ? s1_ff : s2_ff;
    nxt_active_low_interrupt_pin_d = ce ? s2_ff[2] : active_low_interrupt_pin_d_ff;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_ff <= 3'h6;
      s2_ff <= 3'h6;
      active_low_interrupt_pin_d_ff <= 1'h1;
    end
    else
    begin
      s1_ff <= nxt_s1;
      s2_ff <= nxt_s2;
      active_low_interrupt_pin_d_ff <= nxt_active_low_interrupt_pin_d;
    end
  end

  assign sy.on_lvl = s2_ff[0];
  assign sy.rst_lvl_n = s2_ff[1];
  assign sy.active_low_interrupt_pin_fall = ce & active_low_interrupt_pin_d_ff & ~s2_ff[2];

  a_active_low_interrupt_pin_edge_only: assert property (@(posedge clk) disable iff (!rst_n)
    sy.active_low_interrupt_pin_fall |-> $past(s2_ff[2]) && !s2_ff[2])
    else $error("interrupt event without falling edge");
endmodule

// *** verilog/feat_ctl.sv ***
`timescale 1ns/1ps
`include "pwr_defs.svh"
module feat_ctl (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic clr,
  input wire logic feature_mode_command,
  input wire logic [7:0] feature_code,
  output logic int_off_en
);
  logic en_ff;
  logic nxt_en;

  always_comb
  begin
    nxt_en = en_ff;
    if (ce)
    begin
      if (clr)
        nxt_en = 1'h0;
      else if (feature_mode_command && feature_code == `FEAT_INT_OFF_EN)
        nxt_en = 1'h1;
      else if (feature_mode_command && feature_code == `FEAT_INT_OFF_DIS)
        nxt_en = 1'h0;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      en_ff <= 1'h0;
    else
      en_ff <= nxt_en;
  end

  assign int_off_en = en_ff;

  a_feat_disable: assert property (@(posedge clk) disable iff (!rst_n)
    ce && feature_mode_command && feature_code == `FEAT_INT_OFF_DIS |=> !en_ff)
    else $error("feature 84 did not disable interrupt shutdown");
endmodule

// *** verilog/power_reset_boot_control.sv ***
`timescale 1ns/1ps
`include "pwr_defs.svh"
module power_reset_boot_control
  import pwr_pkg::*;
#(
  parameter int unsigned HOLD_CYC = `HOLD_ON_CYC,
  parameter int unsigned POR_CYC = `POR_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic on_pin,
  input wire logic rst_pin_n_in,
  output logic rst_pin_n_out,
  output logic rst_pin_n_oe,
  input wire logic boot_pin,
  input wire logic active_low_interrupt_pin,
  input wire logic init_done,
  input wire logic power_off_command,
  input wire logic feature_mode_command,
  input wire logic [7:0] feature_code,
  output logic ok_ack,
  output logic powered,
  output logic core_rst_n,
  output logic download_mode,
  output logic active_low_interrupt_pin_event
);
  pin_sync_if sy ();
  pwr_state_type st_ff, nxt_st;
  logic [`CNT_W-1:0] cnt_ff, nxt_cnt;
  logic ok_ff, nxt_ok;
  logic oe_ff, nxt_oe;
  logic core_rst_ff, nxt_core_rst;
  logic dl_ff, nxt_dl;
  logic ev_ff, nxt_ev;
  logic int_off_en;
  logic going_off;

  pin_sync u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .on_pin(on_pin),
    .rst_pin_n(rst_pin_n_in),
    .active_low_interrupt_pin(active_low_interrupt_pin),
    .sy(sy)
  );

  feat_ctl u_feat (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .clr(st_ff == ST_OFF),
    .feature_mode_command(feature_mode_command),
    .feature_code(feature_code),
    .int_off_en(int_off_en)
  );

  function automatic logic [`CNT_W-1:0] inc(input logic [`CNT_W-1:0] v);
    inc = v + `CNT_W'(1);
  endfunction

  // Interrupt shutdown only counts while the host has released power control.
  assign going_off = (power_off_command && !sy.on_lvl)
    || (int_off_en && sy.active_low_interrupt_pin_fall && !sy.on_lvl);

  always_comb
  begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    nxt_ok = 1'h0;
    nxt_oe = oe_ff;
    nxt_core_rst = core_rst_ff;
    nxt_dl = dl_ff;
    nxt_ev = 1'h0;
    if (ce)
    begin
      nxt_ev = sy.active_low_interrupt_pin_fall && st_ff == ST_ON;
      case (st_ff)
        ST_OFF:
        begin
          nxt_cnt = '0;
          nxt_oe = 1'h1;
          nxt_core_rst = 1'h0;
          if (sy.on_lvl)
            nxt_st = ST_HOLD;
        end
        ST_HOLD:
        begin
          nxt_oe = 1'h0;
          if (!sy.on_lvl)
            nxt_st = ST_OFF;
          else if (cnt_ff == `CNT_W'(HOLD_CYC - 1))
          begin
            nxt_st = ST_POR;
            nxt_cnt = '0;
          end
          else
            nxt_cnt = inc(cnt_ff);
        end
        ST_POR:
        begin
          nxt_oe = 1'h0;
          nxt_dl = (boot_pin == `BOOT_DOWNLOAD);
          if (cnt_ff == `CNT_W'(POR_CYC - 1))
          begin
            nxt_st = ST_INIT;
            nxt_cnt = '0;
            nxt_oe = 1'h1;
            nxt_core_rst = 1'h1;
          end
          else
            nxt_cnt = inc(cnt_ff);
        end
        ST_INIT:
        begin
          // The pin was driven low until this state began and the synchroniser
          // still shows that low for a few cycles, so it is ignored until settled.
          if (cnt_ff != `CNT_W'(`SYNC_LAT))
            nxt_cnt = inc(cnt_ff);
          else if (!sy.rst_lvl_n)
          begin
            nxt_st = ST_EXT_RST;
            nxt_core_rst = 1'h0;
          end
          else if (init_done)
          begin
            nxt_st = ST_ON;
            nxt_ok = 1'h1;
          end
        end
        ST_ON:
        begin
          // A shutdown request wins over a reset pulled in the same cycle.
          if (going_off)
          begin
            nxt_st = ST_OFF;
            nxt_ok = power_off_command;
            nxt_core_rst = 1'h0;
          end
          else if (!sy.rst_lvl_n)
          begin
            nxt_st = ST_EXT_RST;
            nxt_core_rst = 1'h0;
          end
        end
        ST_EXT_RST:
        begin
          // The strap is followed for as long as reset lasts, so its level at release counts.
          nxt_dl = (boot_pin == `BOOT_DOWNLOAD);
          if (sy.rst_lvl_n)
          begin
            nxt_st = ST_ON;
            nxt_core_rst = 1'h1;
            nxt_ok = 1'h1;
          end
        end
        default:
          nxt_st = ST_OFF;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_ff <= ST_OFF;
      cnt_ff <= '0;
      ok_ff <= 1'h0;
      oe_ff <= 1'h1;
      core_rst_ff <= 1'h0;
      dl_ff <= 1'h0;
      ev_ff <= 1'h0;
    end
    else
    begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      ok_ff <= nxt_ok;
      oe_ff <= nxt_oe;
      core_rst_ff <= nxt_core_rst;
      dl_ff <= nxt_dl;
      ev_ff <= nxt_ev;
    end
  end

  logic pwr_ff;
  logic nxt_pwr;
  // The latch is a flop of its own so the powered output stays registered.
  always_comb
  begin
    nxt_pwr = (nxt_st == ST_POR) || (nxt_st == ST_INIT) || (nxt_st == ST_ON)
      || (nxt_st == ST_EXT_RST);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pwr_ff <= 1'h0;
    else
      pwr_ff <= nxt_pwr;
  end

  assign rst_pin_n_out = 1'h0;
  assign rst_pin_n_oe = oe_ff;
  assign ok_ack = ok_ff;
  assign powered = pwr_ff;
  assign core_rst_n = core_rst_ff;
  assign download_mode = dl_ff;
  assign active_low_interrupt_pin_event = ev_ff;

  a_hold_latch: assert property (@(posedge clk) disable iff (!rst_n)
    st_ff == ST_POR && ce && !sy.on_lvl |=> st_ff != ST_OFF)
    else $error("on state lost after latch");
  a_por_length: assert property (@(posedge clk) disable iff (!rst_n)
    st_ff == ST_POR && cnt_ff < `CNT_W'(POR_CYC - 1) |=> st_ff == ST_POR)
    else $error("power-on reset ended early");
  a_pin_driven_por: assert property (@(posedge clk) disable iff (!rst_n)
    st_ff == ST_POR |-> !rst_pin_n_oe && !core_rst_n)
    else $error("reset pin not driven low in power-on");
  a_ext_rst_hold: assert property (@(posedge clk) disable iff (!rst_n)
    st_ff == ST_EXT_RST |-> !core_rst_n)
    else $error("core left reset while pin low");
  a_ok_after_rst: assert property (@(posedge clk) disable iff (!rst_n)
    st_ff == ST_EXT_RST && ce && sy.rst_lvl_n |=> ok_ack && core_rst_n)
    else $error("no ack after external reset");
  a_init_ok: assert property (@(posedge clk) disable iff (!rst_n)
    st_ff == ST_INIT && cnt_ff == `CNT_W'(`SYNC_LAT) && ce && sy.rst_lvl_n && init_done
    |=> ok_ack && st_ff == ST_ON)
    else $error("no ack after init");
  a_off_cmd: assert property (@(posedge clk) disable iff (!rst_n)
    st_ff == ST_ON && ce && power_off_command && !sy.on_lvl |=> ok_ack ##1 !powered)
    else $error("power-off command not honoured");
  a_active_low_interrupt_pin_off: assert property (@(posedge clk) disable iff (!rst_n)
    st_ff == ST_ON && ce && int_off_en && sy.active_low_interrupt_pin_fall && !sy.on_lvl |=> st_ff == ST_OFF)
    else $error("interrupt shutdown failed");
  a_boot_sample: assert property (@(posedge clk) disable iff (!rst_n)
    st_ff == ST_POR && ce |=> download_mode == !$past(boot_pin))
    else $error("boot strap not sampled");
  a_event_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    active_low_interrupt_pin_event |=> !active_low_interrupt_pin_event)
    else $error("interrupt event longer than a pulse");
  a_hold_refuse: assert property (@(posedge clk) disable iff (!rst_n)
    st_ff == ST_HOLD && ce && !sy.on_lvl |=> st_ff == ST_OFF && !powered)
    else $error("short power request not refused");
  a_por_entry: assert property (@(posedge clk) disable iff (!rst_n)
    st_ff == ST_HOLD && ce && sy.on_lvl && cnt_ff == `CNT_W'(HOLD_CYC - 1)
    |=> st_ff == ST_POR && powered)
    else $error("on state not latched after hold");
  a_core_off: assert property (@(posedge clk) disable iff (!rst_n)
    st_ff == ST_OFF |-> !core_rst_n)
    else $error("core out of reset while off");
  a_oe_off: assert property (@(posedge clk) disable iff (!rst_n)
    st_ff == ST_OFF && ce |=> rst_pin_n_oe)
    else $error("reset pin still driven while off");
  a_off_refused: assert property (@(posedge clk) disable iff (!rst_n)
    st_ff == ST_ON && ce && sy.on_lvl && sy.rst_lvl_n |=> st_ff == ST_ON && !ok_ack)
    else $error("shutdown taken with power control high");
  a_active_low_interrupt_pin_dis_stay: assert property (@(posedge clk) disable iff (!rst_n)
    st_ff == ST_ON && ce && !int_off_en && sy.active_low_interrupt_pin_fall && !power_off_command
    && sy.rst_lvl_n |=> st_ff == ST_ON)
    else $error("interrupt shutdown while disabled");
  a_event_on_only: assert property (@(posedge clk) disable iff (!rst_n)
    active_low_interrupt_pin_event |-> $past(st_ff) == ST_ON)
    else $error("interrupt event outside on state");
  a_dl_hold_on: assert property (@(posedge clk) disable iff (!rst_n)
    st_ff == ST_ON |=> $stable(download_mode))
    else $error("boot strap resampled while on");
  // A low clock enable must leave the sequencer exactly where it was.
  a_ce_freeze: assert property (@(posedge clk) disable iff (!rst_n)
    !ce |=> $stable(st_ff) && $stable(cnt_ff) && $stable(powered))
    else $error("state moved with clock enable low");

  c_power_on: cover property (@(posedge clk) disable iff (!rst_n)
    st_ff == ST_INIT ##[1:20] ok_ack);
  c_ext_reset: cover property (@(posedge clk) disable iff (!rst_n)
    st_ff == ST_EXT_RST ##1 st_ff == ST_ON);
  c_cmd_off: cover property (@(posedge clk) disable iff (!rst_n)
    st_ff == ST_ON && power_off_command ##1 st_ff == ST_OFF);
  c_active_low_interrupt_pin_off: cover property (@(posedge clk) disable iff (!rst_n)
    st_ff == ST_ON && int_off_en && sy.active_low_interrupt_pin_fall);
  c_freeze: cover property (@(posedge clk) disable iff (!rst_n)
    st_ff == ST_ON && !ce);
endmodule

// *** tb/host_model.sv ***
`timescale 1ns/1ps
module host_model (
  input wire logic clk,
  output logic on_pin,
  output logic rst_drive_n,
  output logic boot_pin,
  output logic active_low_interrupt_pin_n,
  output logic off_cmd,
  output logic feat_cmd,
  output logic [7:0] feat_code
);
  initial
  begin
    on_pin = 1'h0;
    rst_drive_n = 1'h1;
    boot_pin = 1'h1;
    active_low_interrupt_pin_n = 1'h1;
    off_cmd = 1'h0;
    feat_cmd = 1'h0;
    feat_code = 8'h00;
  end
  task automatic set_on(input logic v);
    @(negedge clk);
    on_pin = v;
  endtask
  // The pull is held for the full minimum even in a shortened run.
  task automatic pull_rst();
    @(negedge clk);
    rst_drive_n = 1'h0;
    repeat (12500) @(negedge clk);
    rst_drive_n = 1'h1;
  endtask
  task automatic pulse_active_low_interrupt_pin();
    @(negedge clk);
    active_low_interrupt_pin_n = 1'h0;
    repeat (6) @(negedge clk);
    active_low_interrupt_pin_n = 1'h1;
    repeat (6) @(negedge clk);
  endtask
  // The code bus is scrambled when idle, so a stale value cannot help.
  task automatic cmd(input logic off, input logic [7:0] code);
    @(negedge clk);
    off_cmd = off;
    feat_cmd = !off;
    feat_code = code;
    @(negedge clk);
    off_cmd = 1'h0;
    feat_cmd = 1'h0;
    feat_code = ~code;
  endtask
endmodule

// *** tb/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  localparam int POR = 10;
  logic clk, rst_n, init_done, rst_out, rst_oe, ok, pwr, core_n, dl, ev;
  logic on_pin, drv_n, boot, active_low_interrupt_pin_n, off_cmd, f_cmd, ce;
  logic [7:0] f_code;
  wire pin_lvl = drv_n & (rst_oe | rst_out);
  int fails = 0;
  int n_compared = 0;
  int c;
  host_model host (.clk(clk), .on_pin(on_pin), .rst_drive_n(drv_n), .boot_pin(boot),
    .active_low_interrupt_pin_n(active_low_interrupt_pin_n), .off_cmd(off_cmd), .feat_cmd(f_cmd), .feat_code(f_code));
  power_reset_boot_control #(.HOLD_CYC(20), .POR_CYC(POR)) i_dut (.clk(clk), .rst_n(rst_n),
    .ce(ce), .on_pin(on_pin), .rst_pin_n_in(pin_lvl), .rst_pin_n_out(rst_out),
    .rst_pin_n_oe(rst_oe), .boot_pin(boot), .active_low_interrupt_pin(active_low_interrupt_pin_n),
    .init_done(init_done), .power_off_command(off_cmd), .feature_mode_command(f_cmd),
    .feature_code(f_code), .ok_ack(ok), .powered(pwr), .core_rst_n(core_n),
    .download_mode(dl), .active_low_interrupt_pin_event(ev));
  initial
  begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  task automatic wrap_up();
    $display("compared %0d failures %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic e, input logic g);
    n_compared++;
    if (g !== e)
    begin
      $display("ERROR %s expected %0b seen %0b", nm, e, g);
      fails++;
    end
  endtask
  task automatic chk_n(input string nm, input int lo, input int hi, input int g);
    n_compared++;
    if (g < lo || g > hi)
    begin
      $display("ERROR %s expected %0d..%0d seen %0d", nm, lo, hi, g);
      fails++;
    end
  endtask
  function automatic logic hit(input int s);
    case (s)
      0: return pwr === 1'h1;
      1: return core_n === 1'h1;
      2: return ok === 1'h1;
      3: return ev === 1'h1;
      default: return pwr === 1'h0;
    endcase
  endfunction
  task automatic wait_for(input int s, input int lim, output int n);
    n = 0;
    while (!hit(s) && n < lim)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (!hit(s))
    begin
      $display("ERROR wait %0d expected hit seen timeout", s);
      fails++;
      wrap_up();
    end
  endtask
  task automatic t_short();
    host.set_on(1'h1);
    repeat (10) @(negedge clk);
    host.set_on(1'h0);
    repeat (40) @(negedge clk);
    chk("powered", 1'h0, pwr);
  endtask
  task automatic t_power_on(input logic b);
    host.boot_pin = b;
    host.set_on(1'h1);
    wait_for(0, 40, c);
    chk("oe", 1'h0, rst_oe);
    chk("pin", 1'h0, pin_lvl);
    chk("core_rst", 1'h0, core_n);
    host.set_on(1'h0);
    wait_for(1, POR + 5, c);
    chk_n("por_len", POR - 1, POR + 1, c);
    chk("powered", 1'h1, pwr);
    chk("download", !b, dl);
    chk("oe", 1'h1, rst_oe);
    @(negedge clk);
    init_done = 1'h1;
    wait_for(2, 8, c);
    @(negedge clk);
    init_done = 1'h0;
  endtask
  task automatic t_off();
    host.set_on(1'h1);
    repeat (4) @(negedge clk);
    host.cmd(1'h1, 8'h00);
    repeat (4) @(negedge clk);
    chk("powered", 1'h1, pwr);
    host.set_on(1'h0);
    repeat (4) @(negedge clk);
    fork
      host.cmd(1'h1, 8'h00);
      wait_for(2, 4, c);
    join
    wait_for(4, 3, c);
  endtask
  task automatic t_freeze();
    int hits;
    hits = 0;
    ce = 1'h0;
    fork
      host.pulse_active_low_interrupt_pin();
      repeat (13)
      begin
        @(posedge clk);
        #1;
        if (ev !== 1'h0)
          hits++;
      end
    join
    ce = 1'h1;
    chk_n("frozen_events", 0, 0, hits);
    chk("powered", 1'h1, pwr);
  endtask
  task automatic t_ext();
    host.boot_pin = 1'h0;
    fork
      host.pull_rst();
      begin
        repeat (100) @(negedge clk);
        chk("core_rst", 1'h0, core_n);
        chk("download", 1'h1, dl);
        host.boot_pin = 1'h1;
      end
    join
    wait_for(2, 6, c);
    repeat (2) @(negedge clk);
    chk("core_rst", 1'h1, core_n);
    chk("download", 1'h0, dl);
  endtask
  task automatic t_active_low_interrupt_pin();
    fork
      host.pulse_active_low_interrupt_pin();
      wait_for(3, 8, c);
    join_any
    chk_n("active_low_interrupt_pin_lat", 2, 5, c);
    repeat (12) @(negedge clk);
    chk("powered", 1'h1, pwr);
    host.cmd(1'h0, 8'h53);
    host.cmd(1'h0, 8'h54);
    host.pulse_active_low_interrupt_pin();
    chk("powered", 1'h1, pwr);
    host.cmd(1'h0, 8'h53);
    host.set_on(1'h1);
    host.pulse_active_low_interrupt_pin();
    chk("powered", 1'h1, pwr);
    host.set_on(1'h0);
    fork
      host.pulse_active_low_interrupt_pin();
      wait_for(4, 10, c);
    join
  endtask
  initial
  begin
    rst_n = 1'h0;
    init_done = 1'h0;
    ce = 1'h1;
    repeat (4) @(negedge clk);
    rst_n = 1'h1;
    t_short();
    t_power_on(1'h0);
    t_off();
    t_power_on(1'h1);
    t_freeze();
    t_ext();
    t_active_low_interrupt_pin();
    wrap_up();
  end
endmodule
